// ### src/imc_pkg.sv
package imc_pkg;
	localparam int CLK_HZ          = 10_000_000;
	localparam int MAIN_IDLE_S     = 15;
	localparam int CONF_IDLE_S     = 30;
	localparam int STATUS_MS       = 2000;
	localparam int PHASE_MS        = 1000;
	localparam int REPEAT_MS       = 500;
	localparam int MAIN_IDLE_CYC   = MAIN_IDLE_S * CLK_HZ;
	localparam int CONF_IDLE_CYC   = CONF_IDLE_S * CLK_HZ;
	localparam int STATUS_CYC      = STATUS_MS * (CLK_HZ / 1000);
	localparam int PHASE_CYC       = PHASE_MS * (CLK_HZ / 1000);
	localparam int REPEAT_CYC      = REPEAT_MS * (CLK_HZ / 1000);

	// Menu entries, also the index into the value store
	localparam logic [3:0] IT_STF   = 4'h0;
	localparam logic [3:0] IT_WL    = 4'h1;
	localparam logic [3:0] IT_BUGS  = 4'h2;
	localparam logic [3:0] IT_AVG   = 4'h3;
	localparam logic [3:0] IT_DAMP  = 4'h4;
	localparam logic [3:0] IT_CFG   = 4'h5;
	localparam logic [3:0] IT_VOL   = 4'h6;
	localparam logic [3:0] IT_UNITS = 4'h7;
	localparam logic [3:0] IT_RANGE = 4'h8;
	localparam logic [3:0] IT_TOP   = 4'h9;
	localparam logic [3:0] IT_BOT   = 4'ha;
	localparam logic [3:0] IT_MAIN  = 4'hb;
	localparam int         N_ITEMS  = 12;

	// Value limits; stf in 0.5 m/s, wing loading in 0.5 kg/m2
	localparam logic [7:0] STF_MAX   = 8'h0c;
	localparam logic [7:0] WL_MIN    = 8'h28;
	localparam logic [7:0] WL_MAX    = 8'h64;
	localparam logic [7:0] BUGS_MAX  = 8'h14;
	localparam logic [7:0] AVG_MIN   = 8'h02;
	localparam logic [7:0] AVG_MAX   = 8'h78;
	localparam logic [7:0] DAMP_MIN  = 8'h01;
	localparam logic [7:0] DAMP_MAX  = 8'h03;
	localparam logic [7:0] VOL_MAX   = 8'h08;
	localparam logic [7:0] UNITS_MAX = 8'h01;
	localparam logic [7:0] RANGE_MAX = 8'h02;
	localparam logic [7:0] QUANT_MAX = 8'h05;

	typedef enum logic [3:0] {
		M_STATUS = 4'b0001,
		M_VARIO  = 4'b0010,
		M_MAIN   = 4'b0100,
		M_CONF   = 4'b1000
	} imc_mode_e;

	typedef enum logic [2:0] {
		C_STATUS = 3'h0,
		C_AVG    = 3'h1,
		C_NET    = 3'h2,
		C_PROBE  = 3'h3,
		C_PARAM  = 3'h4
	} imc_centre_e;

	typedef struct packed {
		logic sel;
		logic plus;
		logic minus;
	} imc_btn_s;

	typedef struct packed {
		logic [7:0] stf;
		logic [7:0] wl;
		logic [7:0] bugs;
		logic [7:0] avg;
		logic [7:0] damp;
		logic [7:0] vol;
		logic [7:0] units;
		logic [7:0] range;
		logic [7:0] top;
		logic [7:0] bot;
	} imc_set_s;

	typedef struct packed {
		imc_centre_e centre;
		logic        inverse;
		logic [7:0]  top;
		logic [7:0]  bot;
		logic        show_stf;
		logic [3:0]  item;
		logic [7:0]  value;
	} imc_disp_s;
endpackage : imc_pkg

// ### src/imc_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Needle shows number negative, then value positive
// - Needle figures in half scale steps
// - Plus raises, minus lowers, within range
// - Damping 1 to 3; needle numbers 1, 2
// - Plus on config entry opens configuration
// - Select on config entry returns to vario
// - 30 s idle in configuration returns vario
// - Held select steps in configuration; plus on exit leaves
// - Store to memory only on vario return
// - Lost power discards unsaved edits
// - Needle config: volume, units, range entries
// - Needle exit entry returns to main menu
// - Averaging time 2 to 120 s
// - Speed-to-fly 0 to 6, 0.5 steps
// - Wing loading 20 to 50, 0.5 steps
// - Polar degradation 0 to 20 percent
// - Vario centre shows averaged climb, M
// - Speed-command centre shows net, inverse N
// - Top and bottom lines show chosen quantity
// - Speed-command variants show stf on bottom
// - Missing probe data shows probe text
// - Display variants show status at power-up
// - 15 s idle in main menu returns vario
// - Needle variant power-up goes straight to vario
// - Switch open vario, closed speed command
module imc_top
	import imc_pkg::*;
#(
	parameter bit LCD_FITTED   = 1'b1,
	parameter bit STF_FITTED   = 1'b1,
	parameter bit REMOTE_PROBE = 1'b0,
	parameter int MAIN_IDLE    = MAIN_IDLE_CYC,
	parameter int CONF_IDLE    = CONF_IDLE_CYC,
	parameter int STATUS_TIME  = STATUS_CYC,
	parameter int PHASE_TIME   = PHASE_CYC,
	parameter int REPEAT_TIME  = REPEAT_CYC
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	// Pilot controls
	input  wire imc_pkg::imc_btn_s  btn,
	input  wire logic               stf_switch_closed,
	// Measurements
	input  wire logic signed [7:0]  vario_half,
	input  wire logic               probe_data_ok,
	// Non-volatile image
	input  wire imc_pkg::imc_set_s  nv_image,
	output      logic               nv_store,
	output      imc_pkg::imc_set_s  nv_data,
	// Live settings and indication
	output      imc_pkg::imc_set_s  settings,
	output      logic [7:0]         live_volume,
	output      logic               stf_mode,
	output      logic               menu_active,
	output      logic signed [7:0]  needle_half,
	output      imc_pkg::imc_disp_s disp
);
	import imc_pkg::*;

	if (MAIN_IDLE < 1 || CONF_IDLE < 1 || STATUS_TIME < 1 ||
	    PHASE_TIME < 1 || REPEAT_TIME < 1) begin : g_bad_time
		$error("imc_top: timing parameters must be at least one");
	end
	if (STF_FITTED && !LCD_FITTED) begin : g_bad_variant
		$error("imc_top: speed command needs the display variant");
	end

	imc_mode_e  mode;
	logic [3:0] item;
	logic [7:0] vals [N_ITEMS];
	logic [31:0] idle_cnt;
	logic [31:0] rep_cnt;
	logic [31:0] phase_cnt;
	logic        phase_val;
	imc_btn_s    btn_q;
	imc_btn_s    press;
	logic        rep_hit;
	logic        step_sel;
	logic        to_vario;

	function automatic logic [7:0] lo_of(input logic [3:0] it);
		case (it)
			IT_WL:   lo_of = WL_MIN;
			IT_AVG:  lo_of = AVG_MIN;
			IT_DAMP: lo_of = DAMP_MIN;
			default: lo_of = 8'h00;
		endcase
	endfunction : lo_of

	function automatic logic [7:0] hi_of(input logic [3:0] it);
		case (it)
			IT_STF:   hi_of = STF_MAX;
			IT_WL:    hi_of = WL_MAX;
			IT_BUGS:  hi_of = BUGS_MAX;
			IT_AVG:   hi_of = AVG_MAX;
			IT_DAMP:  hi_of = DAMP_MAX;
			IT_VOL:   hi_of = VOL_MAX;
			IT_UNITS: hi_of = UNITS_MAX;
			IT_RANGE: hi_of = RANGE_MAX;
			IT_TOP:   hi_of = QUANT_MAX;
			IT_BOT:   hi_of = QUANT_MAX;
			default:  hi_of = 8'h00;
		endcase
	endfunction : hi_of

	// First main-menu entry depends on fitted features
	function automatic logic [3:0] first_main();
		if (STF_FITTED)
			first_main = IT_STF;
		else if (LCD_FITTED)
			first_main = IT_AVG;
		else
			first_main = IT_DAMP;
	endfunction : first_main

	// Needle variant skips the display-only entries
	function automatic logic [3:0] next_item(input logic [3:0] it);
		if (it == IT_CFG || it == IT_MAIN)
			next_item = it;
		else if (!LCD_FITTED && it == IT_RANGE)
			next_item = IT_MAIN;
		else
			next_item = it + 4'h1;
	endfunction : next_item

	function automatic logic [7:0] needle_num(input logic [3:0] it);
		if (it == IT_MAIN)
			needle_num = 8'h06;
		else
			needle_num = {4'h0, it} - 8'h03;
	endfunction : needle_num

	assign press.sel   = btn.sel & ~btn_q.sel;
	assign press.plus  = btn.plus & ~btn_q.plus;
	assign press.minus = btn.minus & ~btn_q.minus;
	assign rep_hit  = (mode == M_CONF) && btn.sel && btn_q.sel &&
	                  (rep_cnt >= 32'(REPEAT_TIME - 1));
	assign step_sel = press.sel | rep_hit;

	assign to_vario =
		(mode == M_MAIN && item == IT_CFG && press.sel) ||
		(mode == M_MAIN && idle_cnt >= 32'(MAIN_IDLE - 1)) ||
		(mode == M_CONF && idle_cnt >= 32'(CONF_IDLE - 1)) ||
		(mode == M_CONF && item == IT_MAIN && press.plus && LCD_FITTED);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			btn_q <= '0;
		else
			btn_q <= btn;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !btn.sel || rep_hit)
			rep_cnt <= '0;
		else
			rep_cnt <= rep_cnt + 32'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || press != '0 || mode == M_VARIO)
			idle_cnt <= '0;
		else
			idle_cnt <= idle_cnt + 32'h1;
	end

	// Mode and entry walk
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode <= LCD_FITTED ? M_STATUS : M_VARIO;
			item <= first_main();
		end else if (to_vario) begin
			mode <= M_VARIO;
			item <= first_main();
		end else begin
			case (mode)
				M_STATUS: if (idle_cnt >= 32'(STATUS_TIME - 1)) begin
					mode <= M_VARIO;
				end
				M_VARIO: if (press.sel) begin
					mode <= M_MAIN;
					item <= first_main();
				end
				M_MAIN: begin
					if (item == IT_CFG && press.plus) begin
						mode <= M_CONF;
						item <= IT_VOL;
					end else if (step_sel) begin
						item <= next_item(item);
					end
				end
				M_CONF: begin
					// needle exit goes to main menu
					if (item == IT_MAIN && press.plus) begin
						mode <= M_MAIN;
						item <= first_main();
					end else if (step_sel) begin
						item <= next_item(item);
					end
				end
				default: mode <= M_VARIO;
			endcase
		end
	end

	// Working copy; survives until reset, then reloaded from nv_image
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vals[IT_STF]   <= nv_image.stf;
			vals[IT_WL]    <= nv_image.wl;
			vals[IT_BUGS]  <= nv_image.bugs;
			vals[IT_AVG]   <= nv_image.avg;
			vals[IT_DAMP]  <= nv_image.damp;
			vals[IT_CFG]   <= 8'h00;
			vals[IT_VOL]   <= nv_image.vol;
			vals[IT_UNITS] <= nv_image.units;
			vals[IT_RANGE] <= nv_image.range;
			vals[IT_TOP]   <= nv_image.top;
			vals[IT_BOT]   <= nv_image.bot;
			vals[IT_MAIN]  <= 8'h00;
		end else if (mode == M_MAIN || mode == M_CONF) begin
			if (press.plus && vals[item] < hi_of(item))
				vals[item] <= vals[item] + 8'h01;
			else if (press.minus && vals[item] > lo_of(item))
				vals[item] <= vals[item] - 8'h01;
		end
	end

	// Live volume is not stored; start-up volume is
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			live_volume <= nv_image.vol;
		else if (mode == M_VARIO && press.plus && live_volume < VOL_MAX)
			live_volume <= live_volume + 8'h01;
		else if (mode == M_VARIO && press.minus && live_volume != 8'h00)
			live_volume <= live_volume - 8'h01;
	end

	// one store pulse per vario return
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			nv_store <= 1'b0;
			nv_data  <= nv_image;
		end else begin
			nv_store <= to_vario;
			if (to_vario)
				nv_data <= settings;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			settings <= nv_image;
		end else begin
			settings.stf   <= vals[IT_STF];
			settings.wl    <= vals[IT_WL];
			settings.bugs  <= vals[IT_BUGS];
			settings.avg   <= vals[IT_AVG];
			settings.damp  <= vals[IT_DAMP];
			settings.vol   <= vals[IT_VOL];
			settings.units <= vals[IT_UNITS];
			settings.range <= vals[IT_RANGE];
			settings.top   <= vals[IT_TOP];
			settings.bot   <= vals[IT_BOT];
		end
	end

	// Number phase restarts on every press, not on held-select repeat steps
	always_ff @(posedge ref_clk) begin
		if (sys_rst || press != '0 || mode == M_VARIO) begin
			phase_cnt <= '0;
			phase_val <= 1'b0;
		end else if (!phase_val && phase_cnt >= 32'(PHASE_TIME - 1)) begin
			phase_val <= 1'b1;
		end else begin
			phase_cnt <= phase_cnt + 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			needle_half <= '0;
			menu_active <= 1'b0;
			stf_mode    <= 1'b0;
		end else begin
			menu_active <= (mode == M_MAIN || mode == M_CONF);
			stf_mode    <= STF_FITTED && stf_switch_closed;
			if (!LCD_FITTED && (mode == M_MAIN || mode == M_CONF)) begin
				// number in full marks, value in half steps
				if (phase_val)
					needle_half <= vals[item];
				else
					needle_half <= -$signed(8'({needle_num(item), 1'b0}));
			end else begin
				needle_half <= vario_half;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			disp <= '0;
		end else begin
			disp.top      <= vals[IT_TOP];
			disp.bot      <= vals[IT_BOT];
			disp.show_stf <= STF_FITTED;
			disp.item     <= item;
			disp.value    <= vals[item];
			disp.inverse  <= 1'b0;
			if (mode == M_STATUS)
				disp.centre <= C_STATUS;
			else if (mode != M_VARIO)
				disp.centre <= C_PARAM;
			else if (REMOTE_PROBE && !probe_data_ok)
				disp.centre <= C_PROBE;
			else if (STF_FITTED && stf_switch_closed) begin
				disp.centre  <= C_NET;
				disp.inverse <= 1'b1;
			end else
				disp.centre <= C_AVG;
		end
	end
endmodule : imc_top

// ### test/imc_checker.sv
`timescale 1ns/1ns
module imc_checker
	import imc_pkg::*;
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              sys_rst,
	// Observed
	input wire logic              stf_switch_closed,
	input wire logic              nv_store,
	input wire imc_pkg::imc_set_s nv_data,
	input wire imc_pkg::imc_set_s settings,
	input wire logic [7:0]        live_volume,
	input wire logic              stf_mode,
	input wire logic              menu_active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	chk_store_one_pulse: assert property (nv_store |=> !nv_store)
		else $error("store pulse too long");
	chk_store_on_leave: assert property (nv_store |-> menu_active ##1 !menu_active)
		else $error("store without leaving menu");
	chk_leave_stores: assert property ($fell(menu_active) |-> $past(nv_store))
		else $error("menu left without store");
	chk_store_data: assert property (nv_store |-> nv_data == $past(settings))
		else $error("stored data wrong");
	chk_stf_range: assert property (settings.stf <= STF_MAX)
		else $error("stf out of range");
	chk_wl_range: assert property (settings.wl >= WL_MIN && settings.wl <= WL_MAX)
		else $error("wing loading out of range");
	chk_avg_range: assert property (settings.avg inside {[AVG_MIN:AVG_MAX]})
		else $error("averaging time out of range");
	chk_damp_range: assert property (settings.damp inside {[DAMP_MIN:DAMP_MAX]})
		else $error("damping out of range");
	chk_bugs_range: assert property (settings.bugs <= BUGS_MAX)
		else $error("degradation out of range");
	chk_volume_range: assert property (live_volume <= VOL_MAX)
		else $error("volume out of range");
	chk_switch_mode: assert property (stf_mode == $past(stf_switch_closed))
		else $error("mode does not follow switch");

	cover property (nv_store);
	cover property ($rose(stf_mode));
	cover property ($fell(menu_active));
endmodule : imc_checker

bind imc_top imc_checker u_chk (.ref_clk, .sys_rst, .stf_switch_closed,
	.nv_store, .nv_data, .settings, .live_volume, .stf_mode, .menu_active);

// ### test/imc_pilot.sv
`timescale 1ns/1ns
module imc_pilot
	import imc_pkg::*;
#(
	parameter imc_set_s INIT = '0
) (
	// Clock
	input  wire logic              ref_clk,
	// Buttons
	output imc_pkg::imc_btn_s      btn,
	// Stored image
	input  wire logic              nv_store,
	input  wire imc_pkg::imc_set_s nv_data,
	output imc_pkg::imc_set_s      nv_image
);
	initial btn = '0;
	initial nv_image = INIT;
	// Memory keeps only committed values
	always @(posedge ref_clk) if (nv_store === 1'b1) nv_image <= nv_data;

	task automatic set_level(input logic [2:0] m);
		@(negedge ref_clk);
		btn <= m;
	endtask : set_level

	// Release cycle between presses, else no edge
	task automatic press(input logic [2:0] m, input int n);
		repeat (n) begin
			set_level(m);
			set_level(3'h0);
		end
	endtask : press
endmodule : imc_pilot

// ### test/instrument_menu_controller_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module instrument_menu_controller_tb;
	import imc_pkg::*;
	localparam int MI = 50;
	localparam int CI = 80;
	localparam imc_set_s IMG = '{8'h04, 8'h3c, 8'h05, 8'h1e, 8'h02,
		8'h03, 8'h00, 8'h01, 8'h01, 8'h02};
	logic      ref_clk, sys_rst, stf_sw, nv_store, stf_mode, menu_active;
	imc_btn_s  btn;
	imc_set_s  nv_image, nv_data, settings;
	imc_disp_s disp;
	logic [7:0] live_volume;
	logic signed [7:0] needle_half;
	logic signed [7:0] vario_in;
	logic      probe_ok;
	logic [7:0] lo [5];
	logic [7:0] hi [5];
	int mismatches = 0, comparisons = 0, stores = 0, cyc = 0;

	imc_top #(.MAIN_IDLE(MI), .CONF_IDLE(CI), .STATUS_TIME(10),
		.PHASE_TIME(8), .REPEAT_TIME(6)) u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .btn(btn),
		.stf_switch_closed(stf_sw), .vario_half(vario_in),
		.probe_data_ok(probe_ok), .nv_image(nv_image), .nv_store(nv_store),
		.nv_data(nv_data), .settings(settings), .live_volume(live_volume),
		.stf_mode(stf_mode), .menu_active(menu_active),
		.needle_half(needle_half), .disp(disp));
	imc_pilot #(.INIT(IMG)) u_pilot (.ref_clk(ref_clk), .btn(btn),
		.nv_store(nv_store), .nv_data(nv_data), .nv_image(nv_image));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (nv_store === 1'b1) stores++;
	// Hang guard, run needs about 2900 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wait_cyc
	task automatic enter_conf();
		u_pilot.press(3'h4, 6);
		u_pilot.press(3'h2, 1);
		wait_cyc(3);
	endtask : enter_conf
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict

	initial begin
		sys_rst = 1'b1;
		stf_sw = 1'b0;
		vario_in = 8'sh05;
		probe_ok = 1'b1;
		lo = '{8'h00, WL_MIN, 8'h00, AVG_MIN, DAMP_MIN};
		hi = '{STF_MAX, WL_MAX, BUGS_MAX, AVG_MAX, DAMP_MAX};
		wait_cyc(16);
		sys_rst = 1'b0;
		wait_cyc(2);
		`CHK("centre", C_STATUS, disp.centre)
		`CHK("menu", 1'b0, menu_active)
		wait_cyc(14);
		`CHK("centre", C_AVG, disp.centre)
		`CHK("inverse", 1'b0, disp.inverse)
		`CHK("top line", IMG.top, disp.top)
		`CHK("bottom line", IMG.bot, disp.bot)
		vario_in = -8'sh03;
		wait_cyc(2);
		`CHK("needle", -8'sh03, needle_half)
		u_pilot.press(3'h2, 1);
		wait_cyc(3);
		`CHK("volume", IMG.vol + 8'h01, live_volume)
		u_pilot.press(3'h1, 12);
		wait_cyc(3);
		`CHK("volume", 8'h00, live_volume)
		u_pilot.press(3'h4, 1);
		wait_cyc(3);
		`CHK("item", IT_STF, disp.item)
		`CHK("value", IMG.stf, disp.value)
		// Every main item driven past both limits
		for (int i = 0; i < 5; i++) begin
			u_pilot.press(3'h1, 124);
			wait_cyc(3);
			`CHK("low", lo[i], settings[79-8*i -: 8])
			u_pilot.press(3'h2, 124);
			wait_cyc(3);
			`CHK("high", hi[i], settings[79-8*i -: 8])
			u_pilot.press(3'h4, 1);
		end
		wait_cyc(3);
		`CHK("stores", 0, stores)
		`CHK("item", IT_CFG, disp.item)
		u_pilot.press(3'h4, 1);
		wait_cyc(3);
		`CHK("menu", 1'b0, menu_active)
		`CHK("stores", 1, stores)
		for (int i = 0; i < 5; i++)
			`CHK("stored", hi[i], nv_data[79-8*i -: 8])
		enter_conf();
		`CHK("item", IT_VOL, disp.item)
		u_pilot.press(3'h2, 1);
		u_pilot.set_level(3'h4);
		for (int n = 0; n < 100 && disp.item !== IT_MAIN; n++)
			@(negedge ref_clk);
		u_pilot.set_level(3'h0);
		wait_cyc(2);
		`CHK("item", IT_MAIN, disp.item)
		u_pilot.press(3'h2, 1);
		wait_cyc(3);
		`CHK("menu", 1'b0, menu_active)
		`CHK("stored", IMG.vol + 8'h01, nv_data.vol)
		enter_conf();
		u_pilot.press(3'h2, 1);
		wait_cyc(MI + 5);
		`CHK("menu", 1'b1, menu_active)
		wait_cyc(CI - MI);
		`CHK("menu", 1'b0, menu_active)
		`CHK("stores", 3, stores)
		`CHK("stored", IMG.vol + 8'h02, nv_data.vol)
		u_pilot.press(3'h4, 1);
		wait_cyc(3);
		`CHK("menu", 1'b1, menu_active)
		wait_cyc(MI + 5);
		`CHK("menu", 1'b0, menu_active)
		`CHK("stores", 4, stores)
		stf_sw = 1'b1;
		wait_cyc(3);
		`CHK("stf mode", 1'b1, stf_mode)
		`CHK("centre", C_NET, disp.centre)
		`CHK("inverse", 1'b1, disp.inverse)
		`CHK("show stf", 1'b1, disp.show_stf)
		stf_sw = 1'b0;
		wait_cyc(3);
		`CHK("centre", C_AVG, disp.centre)
		probe_ok = 1'b0;
		wait_cyc(3);
		`CHK("centre", C_AVG, disp.centre)
		probe_ok = 1'b1;
		// Edit then lose power before leaving
		u_pilot.press(3'h4, 1);
		u_pilot.press(3'h1, 1);
		wait_cyc(3);
		`CHK("stf", STF_MAX - 8'h01, settings.stf)
		sys_rst = 1'b1;
		wait_cyc(16);
		sys_rst = 1'b0;
		wait_cyc(2);
		`CHK("stf", STF_MAX, settings.stf)
		`CHK("stores", 4, stores)
		print_verdict();
	end
endmodule : instrument_menu_controller_tb
